// file: common/compact_branch_pkg.sv
// Constants and types shared by the compact branch unit
package compact_branch_pkg;

	// Primary opcodes, bits 31-26
	localparam logic [5:0] OP_COP_GROUP  = 6'h11;
	localparam logic [5:0] OP_LINK_LE_GE = 6'h30;
	localparam logic [5:0] OP_LINK_GT_LT = 6'h38;
	localparam logic [5:0] OP_LINK_EQ    = 6'h1D;
	localparam logic [5:0] OP_LINK_NE    = 6'h1F;
	localparam logic [5:0] OP_WIDE_EQ    = 6'h20;
	localparam logic [5:0] OP_WIDE_NE    = 6'h28;

	// Sub-opcodes held in bits 25-21 of the coprocessor group
	localparam logic [4:0] SUB_COP2_CLEAR = 5'h0A;
	localparam logic [4:0] SUB_COP2_SET   = 5'h0B;

	// Field positions
	localparam int OPC_LSB   = 26;
	localparam int FIRST_LSB = 21;
	localparam int SECOND_LSB = 16;
	localparam int REG_W     = 5;
	localparam int OFF_W     = 16;
	localparam int WIDE_OFF_W = 21;

	// Return link register and instruction length
	localparam logic [4:0] LINK_REG   = 5'h1F;
	localparam int         INSTR_BYTES = 4;

	// Reset values
	localparam logic [4:0] REG_RESET = 5'h00;

	typedef enum logic [3:0] {
		kind_none,
		kind_cop2_clear,
		kind_cop2_set,
		kind_link_le,
		kind_link_ge,
		kind_link_gt,
		kind_link_lt,
		kind_link_eq,
		kind_link_ne,
		kind_wide_eq,
		kind_wide_ne
	} kind_type;

endpackage : compact_branch_pkg

// file: design/compact_branch_unit.sv
// Decode and resolve compact conditional branches and link writes
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Cond-clear branch taken when cop2 condition true; cond-set variant inverts it.
// - Cop2 branch target is PC plus 4 plus sign-extended offset shifted left one.
// - All five selector bits go to the coprocessor as the condition specifier.
// - Cop2 branches raise coprocessor-unusable when disabled; reserved when absent.
// - Zero-compare branch-and-link writes PC plus 4 into register 31.
// - The link write happens whether or not the branch is taken.
// - Link branch target is PC plus 4 plus 17-bit signed displacement.
// - Ordering link forms test the register signed: le, ge, lt, gt zero.
// - Equality link forms branch on register equal or not equal zero.
// - No delay slot; next instruction squashed only when the branch is taken.
// - Any instruction may follow a compact branch; no slot restriction checked.
// - Decode looks at register fields as well as the primary opcode.
module compact_branch_unit #(
	parameter int  XLEN        = 32,
	parameter bit  COP2_EXISTS = 1'b1
) (
	// Clock, reset, enable
	input  wire logic            ref_clk,
	input  wire logic            rst_n,
	input  wire logic            clk_en,
	// Fetched instruction
	input  wire logic            instr_valid,
	input  wire logic [31:0]     instr_word,
	input  wire logic [XLEN-1:0] instr_pc,
	// Operand lookups, issued one cycle after the word and answered in that same cycle
	output logic [4:0]           general_register_addr,
	output logic [4:0]           cop2_cond_selector,
	input  wire logic [XLEN-1:0] general_register_value,
	input  wire logic            cop2_cond,
	input  wire logic            cop2_enabled,
	// Resolution
	output logic                 branch_valid,
	output logic                 branch_taken,
	output logic [XLEN-1:0]      branch_target,
	output logic                 squash_next,
	output logic                 link_we,
	output logic [4:0]           link_addr,
	output logic [XLEN-1:0]      link_data,
	output logic                 cop_unusable_exc,
	output logic                 reserved_instr_exc
);

	function automatic logic [XLEN-1:0] sext_shift(input logic [20:0] off, input bit wide);
		logic [XLEN-1:0] r;
		r = '0;
		if (wide) begin
			r = XLEN'($signed({off, 1'b0}));
		end else begin
			r = XLEN'($signed({off[15:0], 1'b0}));
		end
		return r;
	endfunction : sext_shift

	// Field extraction
	wire logic [5:0] opc    = instr_word[compact_branch_pkg::OPC_LSB +: 6];
	wire logic [4:0] first  = instr_word[compact_branch_pkg::FIRST_LSB +: compact_branch_pkg::REG_W];
	wire logic [4:0] second = instr_word[compact_branch_pkg::SECOND_LSB +: compact_branch_pkg::REG_W];
	wire logic       first_nz  = (first != compact_branch_pkg::REG_RESET);
	wire logic       second_z  = (second == compact_branch_pkg::REG_RESET);
	wire logic       same_reg  = (first == second);
	wire logic       order_form = first_nz && second_z;
	wire logic       alt_form   = first_nz && same_reg;

	// Full decode: opcode plus register-field constraints
	compact_branch_pkg::kind_type kind_d;
	always_comb begin
		kind_d = compact_branch_pkg::kind_none;
		unique case (opc)
			compact_branch_pkg::OP_COP_GROUP: begin
				if (first == compact_branch_pkg::SUB_COP2_CLEAR)
					kind_d = compact_branch_pkg::kind_cop2_clear;
				else if (first == compact_branch_pkg::SUB_COP2_SET)
					kind_d = compact_branch_pkg::kind_cop2_set;
			end
			compact_branch_pkg::OP_LINK_LE_GE: begin
				if (order_form)
					kind_d = compact_branch_pkg::kind_link_le;
				else if (alt_form)
					kind_d = compact_branch_pkg::kind_link_ge;
			end
			compact_branch_pkg::OP_LINK_GT_LT: begin
				if (order_form)
					kind_d = compact_branch_pkg::kind_link_gt;
				else if (alt_form)
					kind_d = compact_branch_pkg::kind_link_lt;
			end
			compact_branch_pkg::OP_LINK_EQ: begin
				if (order_form)
					kind_d = compact_branch_pkg::kind_link_eq;
			end
			compact_branch_pkg::OP_LINK_NE: begin
				if (order_form)
					kind_d = compact_branch_pkg::kind_link_ne;
			end
			compact_branch_pkg::OP_WIDE_EQ: begin
				if (first_nz)
					kind_d = compact_branch_pkg::kind_wide_eq;
			end
			compact_branch_pkg::OP_WIDE_NE: begin
				if (first_nz)
					kind_d = compact_branch_pkg::kind_wide_ne;
			end
			default: kind_d = compact_branch_pkg::kind_none;
		endcase
	end

	wire logic is_wide = (kind_d == compact_branch_pkg::kind_wide_eq) ||
		(kind_d == compact_branch_pkg::kind_wide_ne);
	wire logic [XLEN-1:0] next_pc_d = instr_pc + XLEN'(compact_branch_pkg::INSTR_BYTES);
	// Target for all forms: address after branch plus shifted offset
	wire logic [XLEN-1:0] target_d = next_pc_d + sext_shift(instr_word[20:0], is_wide);

	// Stage 1: decoded instruction waiting for operands
	compact_branch_pkg::kind_type kind_q;
	logic [XLEN-1:0] next_pc_q;
	logic [XLEN-1:0] target_q;
	logic [4:0]      reg_addr_q;
	logic [4:0]      selector_q;

	// Taken every enabled cycle: back-to-back branches need no slot check
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			kind_q <= compact_branch_pkg::kind_none;
		end else if (clk_en) begin
			kind_q <= instr_valid ? kind_d : compact_branch_pkg::kind_none;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			next_pc_q <= '0;
		end else if (clk_en) begin
			next_pc_q <= next_pc_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			target_q <= '0;
		end else if (clk_en) begin
			target_q <= target_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_addr_q <= compact_branch_pkg::REG_RESET;
		end else if (clk_en) begin
			reg_addr_q <= first;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			selector_q <= compact_branch_pkg::REG_RESET;
		end else if (clk_en) begin
			selector_q <= second;
		end
	end

	// Stage 2 condition evaluation
	wire logic is_cop2 = (kind_q == compact_branch_pkg::kind_cop2_clear) ||
		(kind_q == compact_branch_pkg::kind_cop2_set);
	wire logic is_link = (kind_q == compact_branch_pkg::kind_link_le) ||
		(kind_q == compact_branch_pkg::kind_link_ge) ||
		(kind_q == compact_branch_pkg::kind_link_gt) ||
		(kind_q == compact_branch_pkg::kind_link_lt) ||
		(kind_q == compact_branch_pkg::kind_link_eq) ||
		(kind_q == compact_branch_pkg::kind_link_ne);
	wire logic val_neg  = general_register_value[XLEN-1];
	wire logic val_zero = (general_register_value == '0);
	// Missing coprocessor wins over disabled coprocessor
	wire logic ri_exc = is_cop2 && !COP2_EXISTS;
	wire logic cu_exc = is_cop2 && COP2_EXISTS && !cop2_enabled;

	logic cond;
	always_comb begin
		cond = 1'b0;
		unique case (kind_q)
			compact_branch_pkg::kind_cop2_clear: cond = cop2_cond;
			compact_branch_pkg::kind_cop2_set:   cond = !cop2_cond;
			compact_branch_pkg::kind_link_le:    cond = val_neg || val_zero;
			compact_branch_pkg::kind_link_ge:    cond = !val_neg;
			compact_branch_pkg::kind_link_lt:    cond = val_neg;
			compact_branch_pkg::kind_link_gt:    cond = !val_neg && !val_zero;
			compact_branch_pkg::kind_link_eq:    cond = val_zero;
			compact_branch_pkg::kind_link_ne:    cond = !val_zero;
			compact_branch_pkg::kind_wide_eq:    cond = val_zero;
			compact_branch_pkg::kind_wide_ne:    cond = !val_zero;
			compact_branch_pkg::kind_none:       cond = 1'b0;
		endcase
	end

	wire logic any_branch = (kind_q != compact_branch_pkg::kind_none);
	// A faulting branch never redirects
	wire logic taken_d = any_branch && cond && !ri_exc && !cu_exc;

	// Stage 2 next values; link fields rest at zero outside a link result
	wire logic [XLEN-1:0] redirect_d  = taken_d ? target_q : next_pc_q;
	wire logic [4:0]      link_addr_d = is_link ? compact_branch_pkg::LINK_REG
		: compact_branch_pkg::REG_RESET;
	wire logic [XLEN-1:0] link_data_d = is_link ? next_pc_q : '0;

	// Stage 2 result flops: each one stands for one enabled cycle
	logic            valid_q;
	logic            taken_q;
	logic [XLEN-1:0] redirect_q;
	logic            squash_q;
	logic            link_we_q;
	logic [4:0]      link_addr_q;
	logic [XLEN-1:0] link_data_q;
	logic            unusable_q;
	logic            reserved_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_q <= 1'b0;
		end else if (clk_en) begin
			valid_q <= any_branch;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			taken_q <= 1'b0;
		end else if (clk_en) begin
			taken_q <= taken_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			redirect_q <= '0;
		end else if (clk_en) begin
			redirect_q <= redirect_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			squash_q <= 1'b0;
		end else if (clk_en) begin
			squash_q <= taken_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_we_q <= 1'b0;
		end else if (clk_en) begin
			link_we_q <= is_link;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_addr_q <= compact_branch_pkg::REG_RESET;
		end else if (clk_en) begin
			link_addr_q <= link_addr_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_data_q <= '0;
		end else if (clk_en) begin
			link_data_q <= link_data_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			unusable_q <= 1'b0;
		end else if (clk_en) begin
			unusable_q <= cu_exc;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reserved_q <= 1'b0;
		end else if (clk_en) begin
			reserved_q <= ri_exc;
		end
	end

	// Outputs straight from their flops, so the pipeline sees no glitches
	assign general_register_addr = reg_addr_q;
	assign cop2_cond_selector    = selector_q;
	assign branch_valid          = valid_q;
	assign branch_taken          = taken_q;
	assign branch_target         = redirect_q;
	assign squash_next           = squash_q;
	assign link_we               = link_we_q;
	assign link_addr             = link_addr_q;
	assign link_data             = link_data_q;
	assign cop_unusable_exc      = unusable_q;
	assign reserved_instr_exc    = reserved_q;

endmodule : compact_branch_unit

`default_nettype wire

// file: test/cbu_asserts.sv
// Port-level checker for the compact branch unit
`timescale 1ns/1ps
`default_nettype none
module cbu_asserts #(
	parameter int XLEN = 32
) (
	// Clock, reset and instruction in
	input wire logic            ref_clk,
	input wire logic            rst_n,
	input wire logic            clk_en,
	input wire logic            instr_valid,
	input wire logic [31:0]     instr_word,
	input wire logic [XLEN-1:0] instr_pc,
	// Lookups
	input wire logic [4:0]      general_register_addr,
	input wire logic [4:0]      cop2_cond_selector,
	input wire logic [XLEN-1:0] general_register_value,
	input wire logic            cop2_cond,
	input wire logic            cop2_enabled,
	// Resolution
	input wire logic            branch_valid,
	input wire logic            branch_taken,
	input wire logic [XLEN-1:0] branch_target,
	input wire logic            squash_next,
	input wire logic            link_we,
	input wire logic [4:0]      link_addr,
	input wire logic [XLEN-1:0] link_data,
	input wire logic            cop_unusable_exc,
	input wire logic            reserved_instr_exc
);
	// Shadow pipe lines up each result with the word and operands behind it
	logic [31:0]     w1_q, w2_q;
	logic [XLEN-1:0] pc1_q, pc2_q, gv_q;
	logic            v1_q, v2_q, cc_q, en_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{w1_q, w2_q, pc1_q, pc2_q, gv_q, v1_q, v2_q, cc_q, en_q} <= '0;
		end else if (clk_en) begin
			{w1_q, w2_q, pc1_q, pc2_q} <= {instr_word, w1_q, instr_pc, pc1_q};
			{gv_q, v1_q, v2_q, cc_q, en_q} <= {general_register_value, instr_valid, v1_q, cop2_cond, cop2_enabled};
		end
	end
	wire logic [5:0]      op2 = w2_q[31:26];
	wire logic            cop2_br = v2_q && op2 == compact_branch_pkg::OP_COP_GROUP && w2_q[25:22] == 4'h5;
	wire logic            wide2 = op2 == compact_branch_pkg::OP_WIDE_EQ || op2 == compact_branch_pkg::OP_WIDE_NE;
	wire logic [XLEN-1:0] off2 = {{(XLEN-17){w2_q[15]}}, w2_q[15:0], 1'b0};
	default clocking cb @(posedge ref_clk iff clk_en);
	endclocking
	default disable iff (!rst_n);
	a_sel_full: assert property (cop2_cond_selector == w1_q[20:16] && general_register_addr == w1_q[25:21])
		else $error("selector or register address wrong");
	a_squash_taken: assert property (squash_next == branch_taken)
		else $error("squash differs from taken");
	a_link_value: assert property (link_we |-> link_addr == 5'h1F && link_data == pc2_q + XLEN'(4))
		else $error("link value wrong");
	a_link_always: assert property (v2_q && op2 == compact_branch_pkg::OP_LINK_NE && w2_q[25:21] != 0 && w2_q[20:16] == 0 |-> link_we && branch_valid)
		else $error("link write missing");
	a_cop2_decide: assert property (cop2_br && en_q |-> branch_valid && branch_taken == (cc_q ^ w2_q[21]))
		else $error("cop2 decision wrong");
	a_cop2_unusable: assert property (cop2_br && !en_q |-> cop_unusable_exc && !branch_taken && !reserved_instr_exc)
		else $error("unusable exception wrong");
	a_target_calc: assert property (branch_taken && !wide2 |-> branch_target == pc2_q + XLEN'(4) + off2)
		else $error("target wrong");
	a_order_le: assert property (branch_valid && op2 == compact_branch_pkg::OP_LINK_LE_GE && w2_q[20:16] == 0 |-> branch_taken == ($signed(gv_q) <= 0))
		else $error("le decision wrong");
	a_eq_zero: assert property (branch_valid && op2 == compact_branch_pkg::OP_LINK_EQ |-> branch_taken == (gv_q == 0))
		else $error("eq decision wrong");
	a_refuse_zero: assert property (v2_q && op2 == compact_branch_pkg::OP_LINK_EQ && w2_q[25:21] == 0 |-> !branch_valid && !link_we)
		else $error("bad encoding accepted");
	c_link_untaken: cover property (link_we && !branch_taken);
	c_unusable: cover property (cop_unusable_exc);
	c_wide_taken: cover property (branch_taken && wide2);
endmodule : cbu_asserts
bind compact_branch_unit cbu_asserts #(.XLEN(XLEN)) chk_u (.*);
`default_nettype wire

// file: test/op_partner.sv
// Register file and coprocessor condition model facing the unit
`timescale 1ns/1ps
`default_nettype none
module op_partner (
	// Lookups from the unit
	input wire logic [4:0]  general_register_addr,
	input wire logic [4:0]  cop2_cond_selector,
	// Flags chosen by the bench
	input wire logic [31:0] cond_flags,
	// Answers
	output logic [31:0]     general_register_value,
	output logic            cop2_cond
);
	logic [31:0] regs_q [32];
	assign general_register_value = regs_q[general_register_addr];
	// One flag per selector value, all five bits used
	assign cop2_cond = cond_flags[cop2_cond_selector];
	task automatic set_reg(input logic [4:0] a, input logic [31:0] v);
		regs_q[a] = v;
	endtask : set_reg
endmodule : op_partner
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the compact branch unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        instr_valid = 1'b0;
	logic        cop2_enabled = 1'b0;
	logic [31:0] instr_word = 32'h0;
	logic [31:0] instr_pc = 32'h0;
	logic [31:0] cond_flags = 32'h0008_0000;
	wire logic [4:0]  ra, cs, la;
	wire logic [31:0] rv, bt, ld;
	wire logic        cc, bv, tk, sq, lw, cu, ri;
	int err_total = 0;
	int compares = 0;
	always #4 ref_clk = ~ref_clk;
	compact_branch_unit dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_pc(instr_pc), .general_register_addr(ra), .cop2_cond_selector(cs),
		.general_register_value(rv), .cop2_cond(cc), .cop2_enabled(cop2_enabled), .branch_valid(bv),
		.branch_taken(tk), .branch_target(bt), .squash_next(sq), .link_we(lw), .link_addr(la), .link_data(ld),
		.cop_unusable_exc(cu), .reserved_instr_exc(ri));
	op_partner peer_u (.general_register_addr(ra), .cop2_cond_selector(cs), .cond_flags(cond_flags),
		.general_register_value(rv), .cop2_cond(cc));
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] tgt(input logic [31:0] pc, input logic [15:0] o, input logic t);
		return t ? pc + 32'h4 + {{15{o[15]}}, o, 1'b0} : pc + 32'h4;
	endfunction : tgt
	// One word in, results read just after they land
	task automatic go(input logic [31:0] w, input logic [31:0] pc, input logic en);
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		instr_pc <= pc;
		cop2_enabled <= en;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask : go
	task automatic t_link();
		logic [31:0] v;
		logic [5:0]  s, op;
		for (int f = 0; f < 6; f++) begin
			for (int k = 0; k < 3; k++) begin
				v = (k == 0) ? 32'hFFFF_FFFF : (k == 1) ? 32'h0 : 32'h7FFF_FFFF;
				peer_u.set_reg(5'h05, v);
				s = {v != 0, v == 0, $signed(v) < 0, $signed(v) > 0, $signed(v) >= 0, $signed(v) <= 0};
				op = (f < 2) ? compact_branch_pkg::OP_LINK_LE_GE : (f < 4) ? compact_branch_pkg::OP_LINK_GT_LT :
					(f == 4) ? compact_branch_pkg::OP_LINK_EQ : compact_branch_pkg::OP_LINK_NE;
				go({op, 5'h05, (f == 1 || f == 3) ? 5'h05 : 5'h00, 16'h8002}, 32'h0001_0000, 1'b1);
				chk({bv, tk, sq, lw, la}, {1'b1, s[f], s[f], 1'b1, 5'h1F});
				chk(ld, 32'h0001_0004);
				chk(bt, tgt(32'h0001_0000, 16'h8002, s[f]));
			end
		end
	endtask : t_link
	task automatic t_cop2();
		logic t;
		for (int n = 0; n < 8; n++) begin
			t = n[1] & (n[2] ^ n[0]);
			go({compact_branch_pkg::OP_COP_GROUP, n[2] ? compact_branch_pkg::SUB_COP2_SET :
				compact_branch_pkg::SUB_COP2_CLEAR, n[0] ? 5'h13 : 5'h12, 16'h7FFF}, 32'h0000_2000, n[1]);
			chk({bv, tk, sq, cu, ri, lw}, {1'b1, t, t, ~n[1], 2'b00});
			chk(bt, tgt(32'h0000_2000, 16'h7FFF, t));
		end
	endtask : t_cop2
	// Wide branch, refused encoding and link branch back to back
	task automatic t_b2b();
		peer_u.set_reg(5'h05, 32'h0);
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr_word <= {compact_branch_pkg::OP_WIDE_EQ, 5'h05, 21'h1F_FFFF};
		instr_pc <= 32'h0000_3000;
		@(posedge ref_clk);
		instr_word <= {compact_branch_pkg::OP_LINK_EQ, 10'h000, 16'h0004};
		@(posedge ref_clk);
		instr_word <= {compact_branch_pkg::OP_LINK_NE, 5'h05, 5'h00, 16'h0004};
		#1;
		chk({bv, tk, sq, lw, bt}, {4'hE, 32'h0000_3002});
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		#1;
		chk({bv, tk, lw, cu}, 4'h0);
		@(posedge ref_clk);
		#1;
		chk({bv, tk, lw, ld}, {3'b101, 32'h0000_3004});
	endtask : t_b2b
	// Wide not-equal branch parked in the pipe while the enable is low
	task automatic t_freeze();
		peer_u.set_reg(5'h06, 32'h0000_0001);
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr_word <= {compact_branch_pkg::OP_WIDE_NE, 5'h06, 21'h00_0010};
		instr_pc <= 32'h0000_4000;
		@(posedge ref_clk);
		instr_word <= {compact_branch_pkg::OP_LINK_EQ, 5'h06, 5'h00, 16'h0004};
		clk_en <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk({bv, sq, lw}, 3'b000);
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		clk_en <= 1'b1;
		@(posedge ref_clk);
		clk_en <= 1'b0;
		#1;
		chk({bv, tk, sq, lw, bt}, {4'hE, 32'h0000_4024});
		@(posedge ref_clk);
		clk_en <= 1'b1;
		#1;
		chk({bv, sq, bt}, {2'b11, 32'h0000_4024});
		@(posedge ref_clk);
		#1;
		chk({bv, tk, sq, lw}, 4'h0);
	endtask : t_freeze
	task automatic results();
		$display("Compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_link();
		t_cop2();
		t_b2b();
		t_freeze();
		results();
	end
endmodule : testbench
`default_nettype wire
